// [verilog/mps_pkg.sv]
// shared constants and types of the multiphase pulse sequencer
// assumes one 50 MHz system clock and a synchronous active-low reset
package mps_pkg;

  // ==========================================================================
  // clock and switching cycle
  // ==========================================================================
  localparam int CLK_HZ         = 50000000; // system clock rate
  localparam int PERIOD_DEF_CYC = 240;      // default cycle, divisible by 12
  localparam int SAMPLE_W_DEF   = 12;       // default sensed current width
  localparam int NUM_CH         = 4;        // channels built in silicon

  // ==========================================================================
  // cycle fractions
  // ==========================================================================
  localparam int DIV_QUARTER    = 4;        // spacing in four channel mode
  localparam int DIV_THIRD      = 3;        // spacing, forced off, window
  localparam int DIV_HALF       = 2;        // spacing in two channel mode
  localparam int DIV_SIXTH      = 6;        // window opening delay
  localparam int STRAP_WAIT_CYC = 3;        // synchroniser fill before capture

  // ==========================================================================
  // channel indices
  // ==========================================================================
  localparam int CH1 = 0;
  localparam int CH2 = 1;
  localparam int CH3 = 2;
  localparam int CH4 = 3;

  // ==========================================================================
  // types
  // ==========================================================================
  // active channel count chosen from the straps
  typedef enum logic [1:0] {
    MPS_MODE_4CH = 2'b00,
    MPS_MODE_3CH = 2'b01,
    MPS_MODE_2CH = 2'b10
  } mps_mode_t;

  // strap capture phase of the top level
  typedef enum logic [1:0] {
    MPS_CFG_WAIT = 2'b00,
    MPS_CFG_RUN  = 2'b01
  } mps_cfg_t;

  // per channel pulse state
  typedef enum logic [1:0] {
    MPS_CH_IDLE   = 2'b00,
    MPS_CH_FORCED = 2'b01,
    MPS_CH_ARMED  = 2'b10,
    MPS_CH_HIGH   = 2'b11
  } mps_ch_state_t;

endpackage : mps_pkg

// [verilog/mps_channel.sv]
// one phase channel: forced off time, rise on ramp crossing, sample window
// assumes term_i is a one-cycle pulse and cross_i is already synchronised
module mps_channel #(
  parameter int CW        = 8,
  parameter int SW        = 12,
  parameter int OFF_CYC   = 80,
  parameter int WIN_START = 40,
  parameter int WIN_END   = 120
) (
  // clock, reset, enable
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // control from the top level
  input  wire logic          active_i,
  input  wire logic          term_i,
  input  wire logic          cross_i,
  input  wire logic [SW-1:0] sensed_current_i,
  // results
  output logic               drive_o,
  output logic               window_o,
  output logic [SW-1:0]      held_o
);
  import mps_pkg::*;

  localparam logic [CW-1:0] OFF_C   = CW'(OFF_CYC);   // forced off length
  localparam logic [CW-1:0] WSTA_C  = CW'(WIN_START); // window open point
  localparam logic [CW-1:0] WEND_C  = CW'(WIN_END);   // window close point
  localparam logic [CW-1:0] CMAX_C  = {CW{1'b1}};     // counter saturation
  localparam logic [CW-1:0] ONE_C   = CW'(1);

  mps_ch_state_t st_ff,    nxt_st;     // pulse state
  logic [CW-1:0] low_ff,   nxt_low;    // cycles since falling edge
  logic          drv_ff,   nxt_drv;    // registered phase drive
  logic          win_ff,   nxt_win;    // registered window flag
  logic [SW-1:0] trk_ff,   nxt_trk;    // tracked current during window
  logic [SW-1:0] hld_ff,   nxt_hld;    // value held for one cycle

  // ==========================================================================
  // next state
  // ==========================================================================
  // term wins unless the channel is disabled, and restarts the cycle low
  always_comb begin
    nxt_st  = st_ff;
    nxt_low = low_ff;
    nxt_trk = trk_ff;
    nxt_hld = hld_ff;
    if (!active_i) begin
      // disabled channel stays quiet, nothing sensed
      nxt_st  = MPS_CH_IDLE;
      nxt_low = '0;
      nxt_trk = '0;
      nxt_hld = '0;
    end else if (term_i) begin
      // cycle starts: fall, latch tracked sample for a full cycle
      nxt_st  = MPS_CH_FORCED;
      nxt_low = '0;
      nxt_hld = trk_ff;
    end else begin
      // count low time, saturating
      if (st_ff != MPS_CH_HIGH && low_ff != CMAX_C) begin
        nxt_low = low_ff + ONE_C;
      end
      unique case (st_ff)
        MPS_CH_IDLE: begin
          // wait for the first termination event
          nxt_st = MPS_CH_IDLE;
        end
        MPS_CH_FORCED: begin
          // hold low for the forced off time
          if (nxt_low >= OFF_C) begin
            nxt_st = MPS_CH_ARMED;
          end
        end
        MPS_CH_ARMED: begin
          // rise on the ramp crossing
          if (cross_i) begin
            nxt_st = MPS_CH_HIGH;
          end
        end
        MPS_CH_HIGH: begin
          // stay high until the next termination
          nxt_st = MPS_CH_HIGH;
        end
      endcase
    end
    // window: low, past the open point, before close point
    nxt_win = (nxt_st == MPS_CH_FORCED || nxt_st == MPS_CH_ARMED) &&
              (nxt_low >= WSTA_C) && (nxt_low < WEND_C);
    nxt_drv = (nxt_st == MPS_CH_HIGH);
    // track the sensed current while the window stands open
    if (win_ff && active_i) begin
      nxt_trk = sensed_current_i;
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  // clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_ff  <= MPS_CH_IDLE;
      low_ff <= '0;
      drv_ff <= 1'b0;
      win_ff <= 1'b0;
      trk_ff <= '0;
      hld_ff <= '0;
    end else if (ce_i) begin
      st_ff  <= nxt_st;
      low_ff <= nxt_low;
      drv_ff <= nxt_drv;
      win_ff <= nxt_win;
      trk_ff <= nxt_trk;
      hld_ff <= nxt_hld;
    end
  end

  assign drive_o  = drv_ff;
  assign window_o = win_ff;
  assign held_o   = hld_ff;

endmodule : mps_channel

// [verilog/mps_sequencer.sv]
// top of the multiphase pulse sequencer: strap capture, cycle counter,
// interleaved termination events and four phase channels
// assumes comparator and strap pins are asynchronous; sensed current words
// come from a converter on clk_i

// Functional notes
// - no strap asserted means four channels
// - termination event pulls phase low, starts cycle
// - four channels fall 4-3-2-1, quarter spaced
// - phase 4 tied high three, 3 two
// - three channels fall 3-2-1, third spaced
// - two channels: second falls half cycle later
// - phase held low one third cycle
// - after off time, rise on ramp crossing
// - high phase stays until next termination
// - window opens sixth in, lasts third unless phase rises first
// - captured current held one full cycle
// - disabled channels keep sensing logic idle
module mps_sequencer #(
  parameter int PERIOD_CYC = mps_pkg::PERIOD_DEF_CYC,
  parameter int SW         = mps_pkg::SAMPLE_W_DEF
) (
  // clock, reset, enable
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      ce_i,
  // phase pins: level read back, drive, enable
  input  wire logic                      phase_drive_3_i,
  input  wire logic                      phase_drive_4_i,
  output logic [mps_pkg::NUM_CH-1:0]     phase_drive_o,
  output logic [mps_pkg::NUM_CH-1:0]     phase_drive_oe_o,
  // ramp crossing comparators, one per channel
  input  wire logic [mps_pkg::NUM_CH-1:0] error_amp_level_i,
  // sensed current words, channel 1 in the low slice
  input  wire logic [mps_pkg::NUM_CH*SW-1:0] sensed_current_i,
  // held samples, sample windows, chosen mode
  output logic [mps_pkg::NUM_CH*SW-1:0]  held_current_o,
  output logic [mps_pkg::NUM_CH-1:0]     sample_window_o,
  output mps_pkg::mps_mode_t             mode_o,
  output logic                           running_o
);
  import mps_pkg::*;

  localparam int CW = $clog2(PERIOD_CYC + 1);           // counter width
  localparam logic [CW-1:0] LAST_C  = CW'(PERIOD_CYC - 1);
  localparam logic [CW-1:0] ONE_C   = CW'(1);
  localparam logic [CW-1:0] Q1_C    = CW'(PERIOD_CYC / DIV_QUARTER);
  localparam logic [CW-1:0] Q2_C    = CW'(2 * PERIOD_CYC / DIV_QUARTER);
  localparam logic [CW-1:0] Q3_C    = CW'(3 * PERIOD_CYC / DIV_QUARTER);
  localparam logic [CW-1:0] T1_C    = CW'(PERIOD_CYC / DIV_THIRD);
  localparam logic [CW-1:0] T2_C    = CW'(2 * PERIOD_CYC / DIV_THIRD);
  localparam logic [CW-1:0] H1_C    = CW'(PERIOD_CYC / DIV_HALF);
  localparam logic [CW-1:0] ZERO_C  = '0;
  localparam int OFF_CYC   = (PERIOD_CYC + DIV_THIRD - 1) / DIV_THIRD;
  localparam int WIN_START = (PERIOD_CYC + DIV_SIXTH - 1) / DIV_SIXTH;
  localparam int WIN_END   = WIN_START + PERIOD_CYC / DIV_THIRD;
  localparam logic [1:0] WAIT_C = 2'(STRAP_WAIT_CYC);

  // ==========================================================================
  // state
  // ==========================================================================
  mps_cfg_t            cfg_ff,   nxt_cfg;   // strap capture phase
  mps_mode_t           mode_ff,  nxt_mode;  // latched channel count
  logic [1:0]          wait_ff,  nxt_wait;  // synchroniser fill count
  logic [CW-1:0]       cnt_ff,   nxt_cnt;   // position in switching cycle
  logic [1:0]          sm_ff,    nxt_sm;    // strap first stage
  logic [1:0]          ss_ff,    nxt_ss;    // strap second stage
  logic [NUM_CH-1:0]   cm_ff,    nxt_cm;    // comparator first stage
  logic [NUM_CH-1:0]   cs_ff,    nxt_cs;    // comparator second stage
  logic [NUM_CH-1:0]   term;                // termination pulses
  logic [NUM_CH-1:0]   active;              // enabled channels
  logic [NUM_CH-1:0]   drive;               // channel drives

  // ==========================================================================
  // next state
  // ==========================================================================
  // synchronisers, strap capture and cycle counter
  always_comb begin
    nxt_sm   = {phase_drive_4_i, phase_drive_3_i};
    nxt_ss   = sm_ff;
    nxt_cm   = error_amp_level_i;
    nxt_cs   = cm_ff;
    nxt_cfg  = cfg_ff;
    nxt_mode = mode_ff;
    nxt_wait = wait_ff;
    nxt_cnt  = cnt_ff;
    unique case (cfg_ff)
      MPS_CFG_WAIT: begin
        // pins released; capture once after synchroniser fills
        if (wait_ff == WAIT_C) begin
          nxt_cfg = MPS_CFG_RUN;
          if (ss_ff[0]) begin
            nxt_mode = MPS_MODE_2CH;
          end else if (ss_ff[1]) begin
            nxt_mode = MPS_MODE_3CH;
          end else begin
            nxt_mode = MPS_MODE_4CH;
          end
        end else begin
          nxt_wait = wait_ff + 2'b01;
        end
      end
      MPS_CFG_RUN: begin
        // one wrap of the counter is one switching cycle
        nxt_cnt = (cnt_ff == LAST_C) ? ZERO_C : cnt_ff + ONE_C;
      end
      default: begin
        nxt_cfg = MPS_CFG_WAIT;
      end
    endcase
  end

  // bit 0 is strap on phase 3 pin, bit 1 on phase 4 pin
  // phase 3 tied high wins: two channel mode

  // termination events per mode
  always_comb begin
    term   = '0;
    active = '0;
    if (cfg_ff == MPS_CFG_RUN) begin
      unique case (mode_ff)
        MPS_MODE_4CH: begin
          // order 4-3-2-1, quarter cycle apart
          active    = 4'hf;
          term[CH4] = (cnt_ff == ZERO_C);
          term[CH3] = (cnt_ff == Q1_C);
          term[CH2] = (cnt_ff == Q2_C);
          term[CH1] = (cnt_ff == Q3_C);
        end
        MPS_MODE_3CH: begin
          // order 3-2-1, third cycle apart
          active    = 4'h7;
          term[CH3] = (cnt_ff == ZERO_C);
          term[CH2] = (cnt_ff == T1_C);
          term[CH1] = (cnt_ff == T2_C);
        end
        MPS_MODE_2CH: begin
          // second channel half a cycle after the first
          active    = 4'h3;
          term[CH1] = (cnt_ff == ZERO_C);
          term[CH2] = (cnt_ff == H1_C);
        end
        default: begin
          active = '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  // clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_ff  <= MPS_CFG_WAIT;
      mode_ff <= MPS_MODE_4CH;
      wait_ff <= 2'h0;
      cnt_ff  <= '0;
      sm_ff   <= 2'h0;
      ss_ff   <= 2'h0;
      cm_ff   <= '0;
      cs_ff   <= '0;
    end else if (ce_i) begin
      cfg_ff  <= nxt_cfg;
      mode_ff <= nxt_mode;
      wait_ff <= nxt_wait;
      cnt_ff  <= nxt_cnt;
      sm_ff   <= nxt_sm;
      ss_ff   <= nxt_ss;
      cm_ff   <= nxt_cm;
      cs_ff   <= nxt_cs;
    end
  end

  // ==========================================================================
  // channels
  // ==========================================================================
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    mps_channel #(
      .CW        (CW),
      .SW        (SW),
      .OFF_CYC   (OFF_CYC),
      .WIN_START (WIN_START),
      .WIN_END   (WIN_END)
    ) u_ch (
      .clk_i            (clk_i),
      .rst_n_i          (rst_n_i),
      .ce_i             (ce_i),
      .active_i         (active[g]),
      .term_i           (term[g]),
      .cross_i          (cs_ff[g]),
      .sensed_current_i (sensed_current_i[g*SW +: SW]),
      .drive_o          (drive[g]),
      .window_o         (sample_window_o[g]),
      .held_o           (held_current_o[g*SW +: SW])
    );
  end

  // disabled pins are left undriven so the strap tie does not fight
  assign phase_drive_o    = drive;
  assign phase_drive_oe_o = active;
  assign mode_o           = mode_ff;
  assign running_o        = (cfg_ff == MPS_CFG_RUN);

endmodule : mps_sequencer

// [bench/mps_checker_assertions.sv]
// checker of the sequencer top ports: modes, spacing, off time, sampling
// assumes ce_i stays high while checks run; bound from the bench top file
module mps_checker
  import mps_pkg::*;
#(
  parameter int PERIOD_CYC = 240,
  parameter int SW         = 12
) (
  // clock, reset, enable
  input wire logic                              clk_i,
  input wire logic                              rst_n_i,
  input wire logic                              ce_i,
  // phase pins and comparators
  input wire logic                              phase_drive_3_i,
  input wire logic                              phase_drive_4_i,
  input wire logic [mps_pkg::NUM_CH-1:0]        phase_drive_o,
  input wire logic [mps_pkg::NUM_CH-1:0]        phase_drive_oe_o,
  input wire logic [mps_pkg::NUM_CH-1:0]        error_amp_level_i,
  // current words, windows, mode
  input wire logic [mps_pkg::NUM_CH*SW-1:0]     sensed_current_i,
  input wire logic [mps_pkg::NUM_CH*SW-1:0]     held_current_o,
  input wire logic [mps_pkg::NUM_CH-1:0]        sample_window_o,
  input wire mps_pkg::mps_mode_t                mode_o,
  input wire logic                              running_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // cycle figures and low-time counters
  // ==========================================================================
  localparam int OFF   = (PERIOD_CYC + 2) / 3; // forced off time
  localparam int WS    = (PERIOD_CYC + 5) / 6; // window opening delay
  localparam int WSM   = WS - 1;               // last closed cycle
  localparam int WL    = PERIOD_CYC / 3;       // window length
  localparam int D_ARM = OFF + 1;              // depth back to the fall
  localparam int Q4    = PERIOD_CYC / 4;
  localparam int Q3    = PERIOD_CYC / 3;
  localparam int Q2    = PERIOD_CYC / 2;
  logic [7:0] lc_ff  [mps_pkg::NUM_CH];        // cycles low since last high
  logic [7:0] nxt_lc [mps_pkg::NUM_CH];
  // count low cycles, saturating
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_lc[i] = phase_drive_o[i] ? 8'h00
                : lc_ff[i] + {7'h00, lc_ff[i] != 8'hff};
    end
  end
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n_i) begin
        lc_ff[i] <= 8'h00;
      end else if (ce_i) begin
        lc_ff[i] <= nxt_lc[i];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // mode and spacing
  // ==========================================================================
  property p_mode_pick;
    $rose(running_o) |-> mode_o == (phase_drive_3_i ? MPS_MODE_2CH :
      phase_drive_4_i ? MPS_MODE_3CH : MPS_MODE_4CH);
  endproperty
  a_mode_pick: assert property (p_mode_pick)
    else $error("mode differs from straps");
  property p_mode_fixed;
    $past(running_o) |-> running_o && $stable(mode_o);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("mode moved while running");
  property p_oe_mask;
    phase_drive_oe_o == (!running_o ? 4'h0 : mode_o == MPS_MODE_4CH ? 4'hf
      : mode_o == MPS_MODE_3CH ? 4'h7 : 4'h3);
  endproperty
  a_oe_mask: assert property (p_oe_mask)
    else $error("pin enables differ from channel count");
  property p_sp4;
    mode_o == MPS_MODE_4CH && $fell(phase_drive_o[3]) |-> ##Q4
      $fell(phase_drive_o[2]) ##Q4 $fell(phase_drive_o[1])
      ##Q4 $fell(phase_drive_o[0]);
  endproperty
  a_sp4: assert property (p_sp4)
    else $error("four channel fall spacing wrong");
  property p_sp3;
    mode_o == MPS_MODE_3CH && $fell(phase_drive_o[2]) |-> ##Q3
      $fell(phase_drive_o[1]) ##Q3 $fell(phase_drive_o[0]);
  endproperty
  a_sp3: assert property (p_sp3)
    else $error("three channel fall spacing wrong");
  property p_sp2;
    mode_o == MPS_MODE_2CH && $fell(phase_drive_o[0]) |-> ##Q2
      $fell(phase_drive_o[1]);
  endproperty
  a_sp2: assert property (p_sp2)
    else $error("two channel fall spacing wrong");
  c_3ch: cover property ($rose(running_o) && mode_o == MPS_MODE_3CH);
  c_2ch: cover property ($rose(running_o) && mode_o == MPS_MODE_2CH);
  c_win: cover property ($fell(sample_window_o[0]) && !phase_drive_o[0]);
  // ==========================================================================
  // per channel timing
  // ==========================================================================
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    property p_low_min;
      $rose(phase_drive_o[g]) |-> lc_ff[g] >= OFF;
    endproperty
    a_low_min: assert property (p_low_min)
      else $error("phase rose before forced off time");
    property p_rise;
      (error_amp_level_i[g] [*4]) ##0 (phase_drive_oe_o[g] && lc_ff[g] ==
        OFF && $past(phase_drive_o[g], D_ARM)) |-> ##[1:3] phase_drive_o[g];
    endproperty
    a_rise: assert property (p_rise)
      else $error("phase did not rise on crossing");
    property p_win_open;
      $fell(phase_drive_o[g]) |-> ##WSM !sample_window_o[g]
        ##1 sample_window_o[g];
    endproperty
    a_win_open: assert property (p_win_open)
      else $error("window opened at wrong time");
    property p_win_span;
      sample_window_o[g] |-> !phase_drive_o[g] &&
        !$past(sample_window_o[g], WL);
    endproperty
    a_win_span: assert property (p_win_span)
      else $error("window open too long or while high");
    property p_held;
      $changed(held_current_o[g*SW +: SW]) |-> $fell(phase_drive_o[g]);
    endproperty
    a_held: assert property (p_held)
      else $error("held sample changed away from a fall");
    property p_idle;
      !phase_drive_oe_o[g] |-> !phase_drive_o[g] && !sample_window_o[g]
        && held_current_o[g*SW +: SW] == '0;
    endproperty
    a_idle: assert property (p_idle)
      else $error("disabled channel is active");
  end
endmodule : mps_checker

// [bench/mps_drv_model.sv]
// far side: driver inputs on the phase pins and board strap ties
// assumes driver inputs have a weak pull-down; a tie to supply overrides
module mps_drv_model (
  // phase drives and enables from the sequencer
  input  wire logic [3:0] drive_i,
  input  wire logic [3:0] oe_i,
  // board straps, high ties the pin to the supply
  input  wire logic       tie3_i,
  input  wire logic       tie4_i,
  // pin levels seen back by the sequencer
  output logic            pin3_o,
  output logic            pin4_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // resolve each pin: tie, else driven level, else pull-down
  assign pin3_o = tie3_i | (oe_i[2] & drive_i[2]);
  assign pin4_o = tie4_i | (oe_i[3] & drive_i[3]);
endmodule : mps_drv_model

// [bench/multiphase_pulse_sequencer_bench.sv]
// self-checking bench of the sequencer with a short switching cycle
// assumes the design files and mps_pkg are compiled first
module multiphase_pulse_sequencer_bench
  import mps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // signals
  // ==========================================================================
  localparam int P  = 24;                     // short cycle, divisible by 12
  localparam int SW = 12;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, tie3 = 1'b0, tie4 = 1'b0;
  logic pin3, pin4, running;
  logic [3:0] amp = 4'h0, drv, oe, win, dprev = 4'h0;
  logic [4*SW-1:0] sens = 48'h444333222111, held;
  mps_mode_t mode;
  int miscompares = 0, compares = 0, cyc = 0, cross_at = 0;
  int lowc[4] = '{0, 0, 0, 0}, fall_t[4], nfall[4], wlen[4];
  int wcur[4] = '{0, 0, 0, 0};
  always #10 clk_i = ~clk_i;
  mps_sequencer #(.PERIOD_CYC(P), .SW(SW)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .phase_drive_3_i(pin3), .phase_drive_4_i(pin4),
    .phase_drive_o(drv), .phase_drive_oe_o(oe), .error_amp_level_i(amp),
    .sensed_current_i(sens), .held_current_o(held),
    .sample_window_o(win), .mode_o(mode), .running_o(running));
  mps_drv_model u_drv (.drive_i(drv), .oe_i(oe), .tie3_i(tie3),
    .tie4_i(tie4), .pin3_o(pin3), .pin4_o(pin4));
  // comparator stimulus, fall and window bookkeeping, hang limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      lowc[i] <= drv[i] ? 0 : lowc[i] + 1;
      amp[i] <= !drv[i] && (lowc[i] >= cross_at);
      dprev[i] <= drv[i];
      if (dprev[i] && !drv[i]) begin
        fall_t[i] <= cyc;
        nfall[i] <= nfall[i] + 1;
      end
      wcur[i] <= win[i] ? wcur[i] + 1 : 0;
      if (!win[i] && wcur[i] != 0) begin
        wlen[i] <= wcur[i];
      end
    end
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input logic [47:0] got, exp, input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  function automatic int off(input mps_mode_t m, input int ch);
    return m == MPS_MODE_4CH ? (3 - ch) * P / 4
         : m == MPS_MODE_3CH ? (2 - ch) * P / 3 : ch * P / 2;
  endfunction : off
  task automatic t_mode(input logic t3, t4, input mps_mode_t m,
                        input logic [3:0] mask);
    int r;
    r = m == MPS_MODE_4CH ? 3 : m == MPS_MODE_3CH ? 2 : 0;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    tie3 <= t3;
    tie4 <= t4;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    nfall = '{0, 0, 0, 0};
    for (int k = 0; k < 10 && running !== 1'b1; k++) @(posedge clk_i) #1;
    chk(48'(mode), 48'(m), "mode");
    chk(48'(oe), 48'(mask), "pin enables");
    repeat (3 * P) @(posedge clk_i);
    tie3 <= ~t3;
    tie4 <= ~t4;
    repeat (2 * P) @(posedge clk_i);
    #1;
    chk(48'(mode), 48'(m), "mode after strap move");
    for (int i = 0; i < 4; i++) begin
      if (mask[i]) begin
        chk(48'(nfall[i] >= 4), 48'h1, "falls per channel");
        chk(48'((fall_t[i] - fall_t[r] + P) % P), 48'(off(m, i)),
            "fall offset");
      end else begin
        chk(48'(nfall[i]), 48'h0, "idle falls");
        chk(48'(held[i*SW +: SW]), 48'h0, "idle sample");
      end
    end
  endtask : t_mode
  task automatic t_sample();
    cross_at = 14;
    @(posedge clk_i);
    sens <= 48'h0d40c30b20a1;
    repeat (3 * P) @(posedge clk_i);
    #1;
    for (int i = 0; i < 4; i++) begin
      chk(48'(held[i*SW +: SW]), 48'h0a1 + 48'(i * 12'h011), "held");
      chk(48'(wlen[i]), 48'(P / 3), "full window");
    end
    cross_at = 0;
    repeat (3 * P) @(posedge clk_i);
    #1;
    for (int i = 0; i < 4; i++) begin
      chk(48'(wlen[i] < P / 3), 48'h1, "window cut by rise");
    end
  endtask : t_sample
  // enable held low from reset through its release freezes strap capture
  task automatic t_hold();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    ce_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    chk(48'(running), 48'h0, "frozen by enable");
    @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    chk(48'(running), 48'h1, "runs after enable");
  endtask : t_hold
  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // main sequence: every strap setting, then the sampling path
  initial begin
    t_mode(1'b0, 1'b1, MPS_MODE_3CH, 4'h7);
    t_mode(1'b1, 1'b0, MPS_MODE_2CH, 4'h3);
    t_mode(1'b1, 1'b1, MPS_MODE_2CH, 4'h3);
    t_hold();
    t_mode(1'b0, 1'b0, MPS_MODE_4CH, 4'hf);
    t_sample();
    wrap_up();
  end
endmodule : multiphase_pulse_sequencer_bench

bind mps_sequencer mps_checker #(.PERIOD_CYC(PERIOD_CYC), .SW(SW)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .phase_drive_3_i(phase_drive_3_i), .phase_drive_4_i(phase_drive_4_i),
  .phase_drive_o(phase_drive_o), .phase_drive_oe_o(phase_drive_oe_o),
  .error_amp_level_i(error_amp_level_i),
  .sensed_current_i(sensed_current_i), .held_current_o(held_current_o),
  .sample_window_o(sample_window_o), .mode_o(mode_o),
  .running_o(running_o));
